// [logic/usy_core.sv]
// Synchronous half-duplex serial port, master and slave, with register port.
// Assumes a 50 MHz core clock; pins are sampled through two flip-flops.
// Behaviour
// - load shift register only after last bit
// - buffer transfer in one cycle, flag sets
// - buffer-empty flag clears only on buffer write; code also reads it clear while transmit enable is off
// - tx enable gates buffer-empty interrupt
// - read-only shift-register-empty status, polled
// - ninth bit sent when nine-bit selected
// - transmit enable set, buffer write starts
// - single or continuous bit enables reception; in slave mode only the continuous bit does
// - receive samples data on falling clock
// - single mode receives one word, stops
// - continuous mode runs until bit cleared
// - continuous bit wins over single bit
// - word done sets flag, enable gates irq
// - clearing continuous bit clears errors
// - slave mode uses external clock only
// - slave mode keeps shifting during sleep
// - second word waits until first finishes
// - flag with enable wakes core, vectors; code does this in slave mode only
// - transmit and receive never overlap
// - master drives clock, enable claims pins
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/10ps
`include "usy_consts.svh"
module usy_core
    import usy_pkg::*;
(
    input  wire logic       i_core_clk,  // 50 MHz core clock
    input  wire logic       i_rst,       // Async reset, high
    input  wire logic [2:0] i_addr,      // Register address
    input  wire logic [7:0] i_wdata,     // Write data
    input  wire logic       i_wr,        // Write strobe
    input  wire logic       i_rd,        // Read strobe
    input  wire logic       i_sleep,     // Core is asleep
    input  wire logic       i_gie,       // Global interrupt enable
    input  wire logic       i_ck_in,     // Clock pin level
    input  wire logic       i_dt_in,     // Data pin level
    output logic [7:0]      o_rdata,     // Read data, cycle after strobe
    output logic            o_ck_out,    // Clock pin drive value
    output logic            o_ck_oe_n,   // Clock pin enable, low drives
    output logic            o_dt_out,    // Data pin drive value
    output logic            o_dt_oe_n,   // Data pin enable, low drives
    output logic            o_irq_high,  // High priority request
    output logic            o_irq_low,   // Low priority request
    output logic            o_wake,      // Wake from sleep
    output logic            o_vector     // Branch to vector
);
    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    usy_tx_ctrl_t transmit_status_control_q;
    usy_rx_ctrl_t receive_status_control_q;
    usy_xfer_t    xfer_q;
    logic [7:0]   peripheral_irq_flags_1_q;
    logic [7:0]   peripheral_irq_enables_1_q;
    logic [7:0]   peripheral_irq_priority_1_q;
    logic [7:0]   transmit_buffer_q;
    logic         tx_buf_ninth_q;
    logic         tx_buf_full_q;
    logic [7:0]   baud_rate_divisor_q;
    logic [7:0]   receive_buffer_q;
    logic         rx_complete_flag_q;
    logic [8:0]   transmit_shift_register_q;
    logic [8:0]   rx_shift_q;
    logic [3:0]   bit_cnt_q;
    logic         ck_q;
    logic [1:0]   ck_sync_q;
    logic [1:0]   dt_sync_q;
    logic         ck_prev_q;

    logic         port_on;
    logic         master;
    logic         tx_buffer_empty_flag;
    logic         tx_irq_enable;
    logic         rx_irq_enable;
    logic         tx_req;
    logic         rx_req;
    logic         rx_want;
    logic         tx_load;
    logic         tick;
    logic         rise;
    logic         fall;
    logic [3:0]   tx_bits;
    logic [3:0]   rx_bits;
    logic         last_bit;
    logic         rx_done;
    logic [8:0]   rx_next;

    function automatic logic wr_at(input logic [2:0] a);
        wr_at = i_wr && (i_addr == a);
    endfunction

    function automatic logic rd_at(input logic [2:0] a);
        rd_at = i_rd && (i_addr == a);
    endfunction

    // -----------------------------------------------------------------------
    // Decode of mode and requests
    // -----------------------------------------------------------------------
    assign port_on = receive_status_control_q.serial_port_enable
                     && transmit_status_control_q.sync_select;
    assign master  = transmit_status_control_q.clock_source_master;
    // Empty buffer reads as flag only while the transmitter is enabled
    assign tx_buffer_empty_flag = transmit_status_control_q.transmit_enable
                                  && !tx_buf_full_q;
    assign tx_irq_enable = peripheral_irq_enables_1_q[`USY_B_TX_IRQ];
    assign rx_irq_enable = peripheral_irq_enables_1_q[`USY_B_RX_IRQ];
    assign tx_req  = tx_buffer_empty_flag && tx_irq_enable;
    assign rx_req  = rx_complete_flag_q && rx_irq_enable;
    // Single-word enable is ignored by a slave
    assign rx_want = port_on && !receive_status_control_q.overrun_error_flag
                     && (receive_status_control_q.continuous_receive_enable
                         || (master && receive_status_control_q.single_receive_enable));
    assign tx_load = port_on && (xfer_q == XF_IDLE) && tx_buf_full_q
                     && transmit_status_control_q.transmit_enable;
    assign tx_bits = transmit_status_control_q.tx_nine_bit_select ? `USY_BITS_9 : `USY_BITS_8;
    assign rx_bits = receive_status_control_q.rx_nine_bit_select ? `USY_BITS_9 : `USY_BITS_8;
    assign rise    = master ? (tick && !ck_q) : (ck_sync_q[1] && !ck_prev_q);
    assign fall    = master ? (tick && ck_q) : (!ck_sync_q[1] && ck_prev_q);
    assign last_bit = fall && (bit_cnt_q == ((xfer_q == XF_TX) ? tx_bits : rx_bits) - 4'h1);
    assign rx_done = (xfer_q == XF_RX) && last_bit;
    assign rx_next = {dt_sync_q[1], rx_shift_q[8:1]};

    // -----------------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ck_sync_q <= 2'h0;
            dt_sync_q <= 2'h0;
            ck_prev_q <= 1'b0;
        end else begin
            ck_sync_q <= {ck_sync_q[0], i_ck_in};
            dt_sync_q <= {dt_sync_q[0], i_dt_in};
            ck_prev_q <= ck_sync_q[1];
        end
    end

    // -----------------------------------------------------------------------
    // Master shift clock
    // -----------------------------------------------------------------------
    // The instruction clock stops in sleep, so a master stalls there
    usy_baud_gen #(
        .W (8)
    ) u_baud (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_run      (master && (xfer_q != XF_IDLE) && !i_sleep),
        .i_div      (baud_rate_divisor_q),
        .o_tick     (tick)
    );

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ck_q <= 1'b0;
        end else if (!master || xfer_q == XF_IDLE) begin
            ck_q <= 1'b0;
        end else if (tick) begin
            ck_q <= !ck_q;
        end
    end

    // -----------------------------------------------------------------------
    // Direction state and bit counter
    // -----------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            xfer_q    <= XF_IDLE;
            bit_cnt_q <= `USY_CNT_ZERO;
        end else begin
            unique case (xfer_q)
                XF_IDLE: begin
                    bit_cnt_q <= `USY_CNT_ZERO;
                    if (tx_load) begin
                        xfer_q <= XF_TX;
                    end else if (rx_want) begin
                        xfer_q <= XF_RX;
                    end
                end
                XF_TX: begin
                    if (!port_on || last_bit) begin
                        xfer_q    <= XF_IDLE;
                        bit_cnt_q <= `USY_CNT_ZERO;
                    end else if (fall) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
                XF_RX: begin
                    if (!rx_want) begin
                        xfer_q <= XF_IDLE;
                    end else if (rx_done) begin
                        bit_cnt_q <= `USY_CNT_ZERO;
                        if (!receive_status_control_q.continuous_receive_enable) begin
                            xfer_q <= XF_IDLE;
                        end
                    end else if (fall) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Transmit path
    // -----------------------------------------------------------------------
    // Slave edges come from the pin, so shifting goes on in sleep
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            transmit_shift_register_q <= 9'h000;
        end else if (tx_load) begin
            transmit_shift_register_q <= {tx_buf_ninth_q, transmit_buffer_q};
        end else if (xfer_q == XF_TX && fall) begin
            transmit_shift_register_q <= {1'b0, transmit_shift_register_q[8:1]};
        end
    end

    // A write in the load cycle wins: the old word moves, the new one stays
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            transmit_buffer_q <= `USY_RST_BYTE;
            tx_buf_ninth_q    <= 1'b0;
            tx_buf_full_q     <= 1'b0;
        end else if (wr_at(`USY_A_TX_BUFFER)) begin
            transmit_buffer_q <= i_wdata;
            tx_buf_ninth_q    <= transmit_status_control_q.tx_ninth_bit;
            tx_buf_full_q     <= 1'b1;
        end else if (tx_load) begin
            tx_buf_full_q <= 1'b0;
        end
    end

    // -----------------------------------------------------------------------
    // Receive path
    // -----------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_shift_q <= 9'h000;
        end else if (xfer_q == XF_RX && fall) begin
            rx_shift_q <= rx_next;
        end
    end

    // A buffer read in the word's last cycle frees room, so the set still wins
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            receive_buffer_q   <= `USY_RST_BYTE;
            rx_complete_flag_q <= 1'b0;
        end else if (rx_done && (!rx_complete_flag_q || rd_at(`USY_A_RX_BUFFER))) begin
            receive_buffer_q   <= receive_status_control_q.rx_nine_bit_select ? rx_next[7:0] : rx_next[8:1];
            rx_complete_flag_q <= 1'b1;
        end else if (rd_at(`USY_A_RX_BUFFER)) begin
            rx_complete_flag_q <= 1'b0;
        end
    end

    // -----------------------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            transmit_status_control_q <= usy_tx_ctrl_t'(`USY_RST_TX_STATUS);
        end else if (wr_at(`USY_A_TX_STATUS)) begin
            transmit_status_control_q <= usy_tx_ctrl_t'(i_wdata);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            receive_status_control_q <= usy_rx_ctrl_t'(`USY_RST_BYTE);
        end else begin
            if (wr_at(`USY_A_RX_STATUS)) begin
                receive_status_control_q.serial_port_enable        <= i_wdata[7];
                receive_status_control_q.rx_nine_bit_select        <= i_wdata[6];
                receive_status_control_q.single_receive_enable     <= i_wdata[5];
                receive_status_control_q.continuous_receive_enable <= i_wdata[4];
                if (!i_wdata[4]) begin
                    receive_status_control_q.overrun_error_flag <= 1'b0;
                end
            end
            if (rx_done) begin
                if (rx_complete_flag_q && !rd_at(`USY_A_RX_BUFFER)) begin
                    receive_status_control_q.overrun_error_flag <= 1'b1;
                end else begin
                    // Eight-bit words leave no stale ninth bit behind
                    receive_status_control_q.rx_ninth_bit <= receive_status_control_q.rx_nine_bit_select
                                                             && rx_next[8];
                end
                if (!receive_status_control_q.continuous_receive_enable) begin
                    receive_status_control_q.single_receive_enable <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            peripheral_irq_flags_1_q    <= `USY_RST_BYTE;
            peripheral_irq_enables_1_q  <= `USY_RST_BYTE;
            peripheral_irq_priority_1_q <= `USY_RST_BYTE;
            baud_rate_divisor_q         <= `USY_RST_BYTE;
        end else begin
            if (wr_at(`USY_A_IRQ_FLAGS)) begin
                peripheral_irq_flags_1_q <= i_wdata;
            end
            if (wr_at(`USY_A_IRQ_ENABLES)) begin
                peripheral_irq_enables_1_q <= i_wdata;
            end
            if (wr_at(`USY_A_IRQ_PRIO)) begin
                peripheral_irq_priority_1_q <= i_wdata;
            end
            if (wr_at(`USY_A_BAUD_DIV)) begin
                baud_rate_divisor_q <= i_wdata;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Read port
    // -----------------------------------------------------------------------
    // Hardware flag bits overlay the stored bits of the shared flag register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= `USY_RST_BYTE;
        end else if (i_rd) begin
            unique case (i_addr)
                `USY_A_IRQ_FLAGS: begin
                    o_rdata <= peripheral_irq_flags_1_q;
                    o_rdata[`USY_B_TX_IRQ] <= tx_buffer_empty_flag;
                    o_rdata[`USY_B_RX_IRQ] <= rx_complete_flag_q;
                end
                `USY_A_IRQ_ENABLES: o_rdata <= peripheral_irq_enables_1_q;
                `USY_A_IRQ_PRIO:    o_rdata <= peripheral_irq_priority_1_q;
                `USY_A_RX_STATUS:   o_rdata <= receive_status_control_q;
                `USY_A_TX_BUFFER:   o_rdata <= transmit_buffer_q;
                `USY_A_TX_STATUS: begin
                    o_rdata    <= transmit_status_control_q;
                    o_rdata[1] <= xfer_q != XF_TX;
                end
                `USY_A_BAUD_DIV:    o_rdata <= baud_rate_divisor_q;
                `USY_A_RX_BUFFER:   o_rdata <= receive_buffer_q;
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Pins and requests
    // -----------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ck_oe_n <= 1'b1;
            o_dt_oe_n <= 1'b1;
            o_dt_out  <= 1'b0;
            o_ck_out  <= 1'b0;
        end else begin
            o_ck_oe_n <= !(port_on && master);
            o_dt_oe_n <= !(port_on && xfer_q == XF_TX);
            o_dt_out  <= transmit_shift_register_q[0];
            o_ck_out  <= ck_q;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_high <= 1'b0;
            o_irq_low  <= 1'b0;
            o_wake     <= 1'b0;
            o_vector   <= 1'b0;
        end else begin
            o_irq_high <= (tx_req && peripheral_irq_priority_1_q[`USY_B_TX_IRQ])
                          || (rx_req && peripheral_irq_priority_1_q[`USY_B_RX_IRQ]);
            o_irq_low  <= (tx_req && !peripheral_irq_priority_1_q[`USY_B_TX_IRQ])
                          || (rx_req && !peripheral_irq_priority_1_q[`USY_B_RX_IRQ]);
            o_wake     <= i_sleep && !master && (tx_req || rx_req);
            o_vector   <= i_sleep && !master && (tx_req || rx_req) && i_gie;
        end
    end

    // -----------------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    chk_load_when_idle: assert property (tx_load |-> xfer_q == XF_IDLE && tx_buf_full_q)
        else $error("shift register loaded while busy");
    chk_load_sets_flag: assert property (tx_load && !i_wr |=> xfer_q == XF_TX && tx_buffer_empty_flag)
        else $error("flag not set one cycle after load");
    chk_flag_write_kept: assert property (tx_buffer_empty_flag && wr_at(`USY_A_IRQ_FLAGS)
        |=> tx_buffer_empty_flag)
        else $error("flag write cleared buffer-empty flag");
    chk_irq_gated: assert property ((o_irq_high || o_irq_low) |-> $past(tx_req || rx_req))
        else $error("request without enabled flag");
    chk_empty_status: assert property (rd_at(`USY_A_TX_STATUS) |=> o_rdata[1] == ($past(xfer_q) != XF_TX))
        else $error("shift-register-empty status wrong");
    chk_rx_on_fall: assert property ((xfer_q == XF_RX) && $changed(rx_shift_q) |-> $past(fall))
        else $error("receive sampled off falling edge");
    chk_single_stops: assert property (rx_done && !receive_status_control_q.continuous_receive_enable
        |=> !receive_status_control_q.single_receive_enable && xfer_q == XF_IDLE)
        else $error("single receive did not stop");
    chk_half_duplex: assert property (xfer_q == XF_TX && port_on |-> !rx_done ##1 !o_dt_oe_n)
        else $error("transmit and receive overlap");
    chk_clock_drive: assert property (o_ck_oe_n == !$past(port_on && master))
        else $error("clock pin drive wrong");
endmodule

// [logic/usy_consts.svh]
// Constants for the synchronous serial port: offsets, bit positions, resets.
// Assumes inclusion by the package and design files of this block only.
`ifndef USY_CONSTS_SVH
`define USY_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define USY_A_IRQ_FLAGS   3'h0
`define USY_A_IRQ_ENABLES 3'h1
`define USY_A_IRQ_PRIO    3'h2
`define USY_A_RX_STATUS   3'h3
`define USY_A_TX_BUFFER   3'h4
`define USY_A_TX_STATUS   3'h5
`define USY_A_BAUD_DIV    3'h6
`define USY_A_RX_BUFFER   3'h7

// ---------------------------------------------------------------------------
// Bit positions and reset values
// ---------------------------------------------------------------------------
`define USY_B_TX_IRQ      4
`define USY_B_RX_IRQ      5
`define USY_RST_BYTE      8'h00
`define USY_RST_TX_STATUS 8'h02
`define USY_CNT_ZERO      4'h0
`define USY_BITS_8        4'h8
`define USY_BITS_9        4'h9

`endif

// [logic/usy_pkg.sv]
// Types shared by the synchronous serial port design files.
// Assumes usy_consts.svh is on the include path.
package usy_pkg;

    // -----------------------------------------------------------------------
    // Control register layouts
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic clock_source_master;
        logic tx_nine_bit_select;
        logic transmit_enable;
        logic sync_select;
        logic addr_detect;
        logic high_speed;
        logic shift_reg_empty_status;
        logic tx_ninth_bit;
    } usy_tx_ctrl_t;

    typedef struct packed {
        logic serial_port_enable;
        logic rx_nine_bit_select;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic unused;
        logic framing_error_flag;
        logic overrun_error_flag;
        logic rx_ninth_bit;
    } usy_rx_ctrl_t;

    // -----------------------------------------------------------------------
    // Link direction state
    // -----------------------------------------------------------------------
    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_TX   = 2'b01,
        XF_RX   = 2'b10
    } usy_xfer_t;

endpackage

// [logic/usy_baud_gen.sv]
// Shift clock rate divider: one-cycle tick every (divisor + 1) core cycles.
// Assumes the divisor is held stable while the divider runs.
`timescale 1ns/10ps
module usy_baud_gen #(
    parameter int W = 8
) (
    input  wire logic         i_core_clk, // Core clock
    input  wire logic         i_rst,      // Async reset, high
    input  wire logic         i_run,      // Divider runs while high
    input  wire logic [W-1:0] i_div,      // Divisor value
    output logic              o_tick      // Half-period enable pulse
);
    logic [W-1:0] cnt_q;

    // Restart from the divisor when idle so the first half period is full
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q  <= '0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_q  <= i_div;
            o_tick <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q  <= i_div;
            o_tick <= 1'b1;
        end else begin
            cnt_q  <= cnt_q - 1'b1;
            o_tick <= 1'b0;
        end
    end
endmodule

// [test/usy_peer.sv]
// Far-side serial device: feeds words onto the data line, records what it sees.
// Assumes the shift clock idles low, whichever side makes it.
`timescale 1ns/10ps
module usy_peer (
    input  wire logic       i_ck,   // Shift clock level
    input  wire logic       i_dt,   // Data line level
    input  wire logic       i_load, // Load word to send
    input  wire logic [7:0] i_byte, // Word to send
    output logic            o_dt,   // Data drive value
    output logic [8:0]      o_got   // Last nine bits seen
);
    logic [7:0] sh_q = 8'h5A;
    always @(posedge i_load) sh_q = i_byte;
    // Rotate so continuous words repeat
    always @(negedge i_ck) sh_q = {sh_q[0], sh_q[7:1]};
    always @(posedge i_ck) o_got = {i_dt, o_got[8:1]};
    assign o_dt = sh_q[0];
endmodule

// [test/usy_core_bench.sv]
// Bench for the serial port: registers, transmit and receive in master mode, transmit in slave mode.
// Assumes usy_peer on the pins; the bench makes the slave shift clock.
`timescale 1ns/10ps
module usy_core_bench;
    import usy_pkg::*;
    logic       clk = 0, rst = 1, wr = 0, rd = 0, ld = 0, n9, slp = 0, gie = 0, sck = 0;
    logic [2:0] addr = 0;
    logic [7:0] wd = 0, rdat, v, b, r;
    logic       ck_o, ck_n, dt_o, dt_n, irq_h, irq_l, pdt, wk, vec;
    logic [8:0] got;
    int         n_fail = 0, num_checks = 0, k, i;
    wire        ck = ck_n ? sck : ck_o;
    wire        dt = dt_n ? pdt : dt_o;
    usy_core u_usy_core (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .i_sleep(slp), .i_gie(gie), .i_ck_in(ck), .i_dt_in(dt), .o_rdata(rdat),
        .o_ck_out(ck_o), .o_ck_oe_n(ck_n), .o_dt_out(dt_o), .o_dt_oe_n(dt_n), .o_irq_high(irq_h),
        .o_irq_low(irq_l), .o_wake(wk), .o_vector(vec));
    usy_peer u_usy_peer (.i_ck(ck), .i_dt(dt), .i_load(ld), .i_byte(r), .o_dt(pdt), .o_got(got));
    initial forever #10 clk = ~clk;
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= w; rd <= ~w; addr <= a; wd <= d;
        @(posedge clk);
        wr <= 0; rd <= 0;
        #1 v = rdat;
    endtask
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Bounded poll until all bits of m read back set
    task automatic poll(input logic [2:0] a, input logic [7:0] m);
        v = 0;
        for (i = 0; i < 400 && (v & m) !== m; i++) bus(0, a, 0);
        if ((v & m) !== m) begin
            n_fail++;
            $display("unexpected at %0t: poll timed out", $time);
        end
    endtask
    // Slave shift clock: one word, 160 ns period, moved off the sampling edge
    task automatic sclk;
        repeat (16) begin
            repeat (4) @(negedge clk);
            sck = ~sck;
        end
    endtask
    function automatic logic [8:0] expw(input logic nine, input logic bit9, input logic [7:0] d);
        return nine ? {bit9, d} : {d, 1'b0};
    endfunction
    task conclude;
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200000 n_fail++;
        conclude;
    end
    initial begin
        void'($urandom(24554));
        repeat (20) @(posedge clk);
        rst <= 0;
        for (k = 0; k < 8; k++) begin
            bus(0, k[2:0], 0);
            chk(v, k == 5 ? 8'h02 : 8'h00);
        end
        bus(1, 6, 8'h07);
        bus(1, 3, 8'h80);
        bus(1, 5, 8'hB0);
        bus(1, 1, 8'h10);
        bus(0, 0, 0);
        chk(v, 8'h10);
        chk(irq_l, 1);
        bus(1, 0, 8'h00);
        bus(0, 0, 0);
        chk(v, 8'h10);
        for (k = 0; k < 2; k++) begin
            n9 = 1'($urandom);
            b = 8'($urandom);
            bus(1, 5, {1'b1, k[0], 5'b11000, n9});
            bus(1, 4, 8'($urandom));
            bus(1, 4, b);
            bus(0, 0, 0);
            chk(v, 8'h00);
            bus(0, 5, 0);
            chk(v[1], 0);
            poll(0, 8'h10);
            poll(5, 8'h02);
            chk(got & {8'hFF, k[0]}, expw(k[0], n9, b));
        end
        r = 8'($urandom);
        ld <= 1;
        bus(1, 1, 8'h20);
        ld <= 0;
        bus(1, 2, 8'h20);
        bus(0, 3, 0);
        chk(v, 8'h80);
        bus(1, 3, 8'hA0);
        poll(0, 8'h20);
        chk(irq_h, 1);
        bus(0, 3, 0);
        chk(v, 8'h80);
        bus(0, 7, 0);
        chk(v, r);
        repeat (300) @(posedge clk);
        bus(0, 0, 0);
        chk(v[5], 0);
        r = 8'($urandom);
        ld <= 1;
        bus(1, 3, 8'hB0);
        for (k = 0; k < 2; k++) begin
            poll(0, 8'h20);
            bus(0, 7, 0);
            chk(v, r);
        end
        // Two unread words: the second one overruns
        repeat (300) @(posedge clk);
        bus(0, 3, 0);
        chk(v, 8'hB2);
        bus(1, 3, 8'h80);
        bus(0, 3, 0);
        chk(v, 8'h80);
        // Slave transmit in sleep, shift clock from the bench
        bus(1, 5, 8'h30);
        bus(1, 1, 8'h10);
        slp <= 1;
        gie <= 1;
        bus(1, 4, b);
        bus(1, 4, r);
        bus(0, 0, 0);
        chk({v[4], wk}, 2'b00);
        sclk;
        repeat (8) @(posedge clk);
        bus(0, 0, 0);
        chk({v[4], wk, vec, ck_n}, 4'hF);
        chk(got[8:1], b);
        sclk;
        repeat (8) @(posedge clk);
        chk(got[8:1], r);
        conclude;
    end
endmodule
